// File: rtl/sfl_baud.v
// master serial clock divider: one-cycle tick per half sck period
// assumes i_run drops between bytes so each byte starts aligned
`timescale 1ns/10ps
`default_nettype none
`include "sfl_defines.vh"
module sfl_baud (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_run,
  input wire [2:0] i_rate,
  output reg o_tick
);
  reg [6:0] cnt_reg;
  wire [6:0] half;
  function [6:0] half_of;
    input [2:0] rate;
    begin
      case (rate)
        `SFL_RATE_4: half_of = `SFL_HALF_4;
        `SFL_RATE_8: half_of = `SFL_HALF_8;
        `SFL_RATE_16: half_of = `SFL_HALF_16;
        `SFL_RATE_32: half_of = `SFL_HALF_32;
        `SFL_RATE_64: half_of = `SFL_HALF_64;
        `SFL_RATE_128: half_of = `SFL_HALF_128;
        // unlisted codes fall back to the slowest safe rate
        default: half_of = `SFL_HALF_128;
      endcase
    end
  endfunction
  assign half = half_of(i_rate);
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= `SFL_HALF_RST;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_reg <= `SFL_HALF_RST;
      o_tick <= 1'b0;
    end else if (cnt_reg == half - `SFL_HALF_ONE) begin
      cnt_reg <= `SFL_HALF_RST;
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + `SFL_HALF_ONE;
      o_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtl/sfl_defines.vh
// constants shared by the serial transfer and fault block
// assumes inclusion by bare name from files under rtl/
`ifndef SFL_DEFINES_VH
`define SFL_DEFINES_VH
// register addresses on the plain register port
`define SFL_ADDR_DATA 8'h21
`define SFL_ADDR_CTRL 8'h22
`define SFL_ADDR_STAT 8'h23
// control register fields
`define SFL_CR_IE 7
`define SFL_CR_PE 6
`define SFL_CR_R2 5
`define SFL_CR_MS 4
`define SFL_CR_POL 3
`define SFL_CR_PHA 2
`define SFL_CR_R1 1
`define SFL_CR_R0 0
// status register fields
`define SFL_SR_DONE 7
`define SFL_SR_WRITE_COLLISION_FLAG 6
`define SFL_SR_MODE_FAULT_FLAG 4
// reset values
`define SFL_CR_RST 8'h00
`define SFL_BYTE_RST 8'h00
`define SFL_CNT_RST 4'h0
`define SFL_SYNC_RST 4'h1
// edge counter: sixteen sck edges make one byte
`define SFL_LAST_EDGE 4'hF
`define SFL_FIRST_EDGE 4'h0
`define SFL_CNT_ONE 4'h1
// half serial periods in cpu cycles, rate code {r2, r1, r0}
`define SFL_RATE_4 3'h4
`define SFL_RATE_8 3'h0
`define SFL_RATE_16 3'h1
`define SFL_RATE_32 3'h6
`define SFL_RATE_64 3'h2
`define SFL_RATE_128 3'h3
`define SFL_HALF_4 7'h02
`define SFL_HALF_8 7'h04
`define SFL_HALF_16 7'h08
`define SFL_HALF_32 7'h10
`define SFL_HALF_64 7'h20
`define SFL_HALF_128 7'h40
`define SFL_HALF_ONE 7'h01
`define SFL_HALF_RST 7'h00
`endif

// File: rtl/sfl_spi_top.v
// serial peripheral byte engine: shift, clock timing, collision and fault logic
// assumes a single-cycle register port on i_ref_clk and asynchronous serial pins
`timescale 1ns/10ps
`default_nettype none
`include "sfl_defines.vh"
// Summary of operation
// - each byte shifts out and in together over exactly eight sck pulses
// - clock idle level bit sets master sck resting level; slave counts either edge, ignores it
// - phase bit set: msb captured on second sck edge
// - phase bit clear: msb captured on first sck edge
// - master puts each bit on mosi one edge before its capture edge
// - slave, phase clear, with select low freezes data register, writes refused
// - data write during a transfer is dropped, transfer goes on
// - slave, phase set: first sck edge freezes data and drives msb on miso
// - master collision only while its own sck is running a byte
// - collision sets write collision flag, never an interrupt
// - select low as master: mode fault, pin enable and master cleared
// - mode fault clears by status access then control write
// - while mode fault set, pin enable and master can be set only by the clearing control write
// - mode fault never sets in slave mode, may stay set
// - on overrun the receive buffer keeps the first byte, rest dropped
// - data reads return the receive buffer, synchronous to the cpu
// - wait mode: normal operation, interrupt request wakes cpu
// - halt: transfer, control and flag registers frozen, reads still served, no wake from here
// - done and fault share one request, gated by enable and cpu mask
// - done flag set per byte, cleared by status then data access
// - msb first from an eight-bit shift register loaded in parallel
// - pin enable connects the block to the pins, else released
// - master select drives sck and swaps mosi and miso directions
module sfl_spi_top (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_int_mask,
  input wire i_halt,
  input wire i_sck,
  output reg o_sck,
  output reg o_sck_oe_n,
  input wire i_mosi,
  output reg o_mosi,
  output reg o_mosi_oe_n,
  input wire i_miso,
  output reg o_miso,
  output reg o_miso_oe_n,
  input wire i_ss_n,
  output reg o_irq
);
  reg [7:0] ctrl_reg;
  reg done_flag_reg;
  reg write_collision_flag_flag_reg;
  reg mode_fault_flag_flag_reg;
  reg arm_done_reg;
  reg arm_write_collision_flag_reg;
  reg arm_mode_fault_flag_reg;
  reg [7:0] shift_reg;
  reg cap_reg;
  reg [7:0] rxbuf_reg;
  reg [3:0] cnt_reg;
  reg busy_reg;
  reg sck_reg;
  reg sck_d_reg;
  reg [7:0] ctrl_next;
  wire [3:0] pins_s;
  wire sck_s;
  wire mosi_s;
  wire miso_s;
  wire ss_s;
  wire tick;
  wire run;
  wire pe;
  wire ms;
  wire pol;
  wire pha;
  wire ie;
  wire dat_wr;
  wire dat_acc;
  wire ctl_wr;
  wire st_acc;
  wire st_rd;
  wire master_on;
  wire slave_on;
  wire fault;
  wire m_edge;
  wire s_edge;
  wire edge_ev;
  wire cap_edge;
  wire last;
  wire in_bit;
  wire [7:0] done_byte;
  wire coll;
  wire blocked;
  wire load;
  wire done_ev;
  wire slave_drive;

  sfl_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pins({i_sck, i_mosi, i_miso, i_ss_n}),
    .o_pins(pins_s)
  );

  assign sck_s = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign ss_s = pins_s[0];

  // halt freezes the engine, control and flag registers; read port, request and synchronisers keep running
  assign run = ~i_halt;
  assign pe = ctrl_reg[`SFL_CR_PE];
  assign ms = ctrl_reg[`SFL_CR_MS];
  assign pol = ctrl_reg[`SFL_CR_POL];
  assign pha = ctrl_reg[`SFL_CR_PHA];
  assign ie = ctrl_reg[`SFL_CR_IE];

  assign dat_wr = i_wr & (i_addr == `SFL_ADDR_DATA);
  assign dat_acc = (i_wr | i_rd) & (i_addr == `SFL_ADDR_DATA);
  assign ctl_wr = i_wr & (i_addr == `SFL_ADDR_CTRL);
  assign st_acc = (i_wr | i_rd) & (i_addr == `SFL_ADDR_STAT);
  assign st_rd = i_rd & (i_addr == `SFL_ADDR_STAT);

  assign master_on = pe & ms;
  assign slave_on = pe & ~ms & ~ss_s;
  // only a master can fault, so a slave never raises the flag
  assign fault = master_on & ~ss_s;

  sfl_baud u_baud (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(run & master_on & busy_reg),
    .i_rate({ctrl_reg[`SFL_CR_R2], ctrl_reg[`SFL_CR_R1], ctrl_reg[`SFL_CR_R0]}),
    .o_tick(tick)
  );

  assign m_edge = master_on & busy_reg & tick;
  assign s_edge = slave_on & (sck_s != sck_d_reg);
  assign edge_ev = run & ~fault & (m_edge | s_edge);
  // even edges capture with phase clear, odd edges with phase set
  assign cap_edge = pha ? cnt_reg[0] : ~cnt_reg[0];
  assign last = (cnt_reg == `SFL_LAST_EDGE);
  assign in_bit = ms ? miso_s : mosi_s;
  assign done_byte = pha ? {shift_reg[6:0], in_bit} : {shift_reg[6:0], cap_reg};
  assign done_ev = edge_ev & last;

  // phase clear slave can be clocked any time select is low
  assign slave_drive = slave_on & (~pha | busy_reg);
  assign coll = dat_wr & ((master_on & busy_reg) | slave_drive);
  // writes stay inhibited until the status register has been seen
  assign blocked = done_flag_reg & ~arm_done_reg;
  assign load = run & dat_wr & ~coll & ~blocked;

  // transfer engine: edge counter, shift register, master clock
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg <= `SFL_BYTE_RST;
      cap_reg <= 1'b0;
      cnt_reg <= `SFL_CNT_RST;
      busy_reg <= 1'b0;
      sck_reg <= 1'b0;
      sck_d_reg <= 1'b0;
    end else if (run) begin
      sck_d_reg <= sck_s;
      if (fault) begin
        busy_reg <= 1'b0;
        cnt_reg <= `SFL_CNT_RST;
        sck_reg <= pol;
      end else if (load) begin
        shift_reg <= i_wdata;
        cnt_reg <= `SFL_CNT_RST;
        busy_reg <= master_on;
        sck_reg <= pol;
      end else if (edge_ev) begin
        if (m_edge) begin
          sck_reg <= ~sck_reg;
        end
        if (cap_edge) begin
          cap_reg <= in_bit;
        end
        if (last) begin
          // sent byte is replaced in place by the byte received
          shift_reg <= done_byte;
          busy_reg <= 1'b0;
          cnt_reg <= `SFL_CNT_RST;
        end else begin
          // phase set: first edge only presents the msb, no shift yet
          if (~cap_edge & ~(pha & (cnt_reg == `SFL_FIRST_EDGE))) begin
            shift_reg <= {shift_reg[6:0], cap_reg};
          end
          busy_reg <= 1'b1;
          cnt_reg <= cnt_reg + `SFL_CNT_ONE;
        end
      end else if (~master_on & ~slave_on) begin
        // select high ends any partial slave byte
        busy_reg <= 1'b0;
        cnt_reg <= `SFL_CNT_RST;
        sck_reg <= pol;
      end else if (~busy_reg) begin
        sck_reg <= pol;
      end
    end
  end

  // control register with fault overrides
  always @* begin
    ctrl_next = ctrl_reg;
    if (ctl_wr) begin
      ctrl_next = i_wdata;
      if (mode_fault_flag_flag_reg & ~arm_mode_fault_flag_reg) begin
        // only the clearing write may raise these two bits again
        ctrl_next[`SFL_CR_PE] = i_wdata[`SFL_CR_PE] & ctrl_reg[`SFL_CR_PE];
        ctrl_next[`SFL_CR_MS] = i_wdata[`SFL_CR_MS] & ctrl_reg[`SFL_CR_MS];
      end
    end
    if (fault) begin
      ctrl_next[`SFL_CR_PE] = 1'b0;
      ctrl_next[`SFL_CR_MS] = 1'b0;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= `SFL_CR_RST;
    end else if (run) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // status flags; a hardware set always beats a same-cycle clear
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_flag_reg <= 1'b0;
      write_collision_flag_flag_reg <= 1'b0;
      mode_fault_flag_flag_reg <= 1'b0;
      arm_done_reg <= 1'b0;
      arm_write_collision_flag_reg <= 1'b0;
      arm_mode_fault_flag_reg <= 1'b0;
    end else if (run) begin
      if (done_ev) begin
        done_flag_reg <= 1'b1;
      end else if (dat_acc & arm_done_reg) begin
        done_flag_reg <= 1'b0;
        arm_done_reg <= 1'b0;
      end else if (st_acc & done_flag_reg) begin
        arm_done_reg <= 1'b1;
      end
      if (coll) begin
        write_collision_flag_flag_reg <= 1'b1;
      end else if (dat_acc & arm_write_collision_flag_reg) begin
        write_collision_flag_flag_reg <= 1'b0;
        arm_write_collision_flag_reg <= 1'b0;
      end else if (st_rd & write_collision_flag_flag_reg) begin
        arm_write_collision_flag_reg <= 1'b1;
      end
      if (fault) begin
        mode_fault_flag_flag_reg <= 1'b1;
      end else if (ctl_wr & arm_mode_fault_flag_reg) begin
        mode_fault_flag_flag_reg <= 1'b0;
        arm_mode_fault_flag_reg <= 1'b0;
      end else if (st_acc & mode_fault_flag_flag_reg) begin
        arm_mode_fault_flag_reg <= 1'b1;
      end
    end
  end

  // receive buffer: only the first byte after a clear is kept
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rxbuf_reg <= `SFL_BYTE_RST;
    end else if (done_ev & ~done_flag_reg) begin
      rxbuf_reg <= done_byte;
    end
  end

  // register read port: data valid the cycle after the strobe only
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `SFL_BYTE_RST;
    end else if (i_rd) begin
      case (i_addr)
        `SFL_ADDR_DATA: o_rdata <= rxbuf_reg;
        `SFL_ADDR_CTRL: o_rdata <= ctrl_reg;
        `SFL_ADDR_STAT: o_rdata <= {done_flag_reg, write_collision_flag_flag_reg, 1'b0, mode_fault_flag_flag_reg,
                                    4'h0};
        default: o_rdata <= `SFL_BYTE_RST;
      endcase
    end else begin
      o_rdata <= `SFL_BYTE_RST;
    end
  end

  // pin drivers; enables are low while driving
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sck <= 1'b0;
      o_sck_oe_n <= 1'b1;
      o_mosi <= 1'b0;
      o_mosi_oe_n <= 1'b1;
      o_miso <= 1'b0;
      o_miso_oe_n <= 1'b1;
    end else if (run) begin
      o_sck <= sck_reg;
      o_sck_oe_n <= ~master_on;
      o_mosi <= shift_reg[7];
      o_mosi_oe_n <= ~master_on;
      o_miso <= shift_reg[7];
      // phase set: low select alone does not drive miso
      o_miso_oe_n <= ~slave_drive;
    end
  end

  // shared request; collisions deliberately stay out of it
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= ie & (done_flag_reg | mode_fault_flag_flag_reg) & ~i_int_mask;
    end
  end
endmodule
`default_nettype wire

// File: rtl/sfl_sync.v
// two-stage synchroniser for the four serial pins
// assumes pins are asynchronous to i_ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "sfl_defines.vh"
module sfl_sync (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [3:0] i_pins,
  output reg [3:0] o_pins
);
  reg [3:0] meta_reg;
  // select idles high so a fresh reset never looks like a fault
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= `SFL_SYNC_RST;
      o_pins <= `SFL_SYNC_RST;
    end else begin
      meta_reg <= i_pins;
      o_pins <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: sim/sfl_asserts.sv
// checker for the serial block: pin directions, read slot, fault, halt, irq
// assumes it is bound to sfl_spi_top and samples on i_ref_clk
`timescale 1ns/10ps
`default_nettype none
module sfl_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_rd,
  input wire logic i_halt,
  input wire logic i_int_mask,
  input wire logic i_ss_n,
  input wire logic [7:0] o_rdata,
  input wire logic o_sck,
  input wire logic o_sck_oe_n,
  input wire logic o_mosi,
  input wire logic o_mosi_oe_n,
  input wire logic o_miso_oe_n,
  input wire logic o_irq
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  read_slot_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  master_pins_a: assert property (!o_sck_oe_n |-> !o_mosi_oe_n && o_miso_oe_n)
    else $error("master pin directions wrong");
  slave_pins_a: assert property (!o_miso_oe_n |-> o_sck_oe_n && o_mosi_oe_n)
    else $error("slave pin directions wrong");
  fault_release_a: assert property ($fell(i_ss_n) && !o_sck_oe_n |-> ##[1:6] o_sck_oe_n && o_mosi_oe_n)
    else $error("outputs kept after select low");
  irq_mask_a: assert property ($past(i_int_mask) && !$past(i_halt) |-> !o_irq)
    else $error("request while masked");
  halt_freeze_a: assert property (i_halt && $past(i_halt) |-> $stable(o_sck) && $stable(o_mosi) && $stable(o_irq))
    else $error("outputs moved in halt");
  miso_select_a: assert property (i_ss_n && $past(i_ss_n) && $past(i_ss_n, 4) && !i_halt |-> o_miso_oe_n)
    else $error("miso driven while deselected");
  sck_spacing_a: assert property (!o_sck_oe_n && !$past(o_sck_oe_n) && $changed(o_sck) |=> $stable(o_sck))
    else $error("sck edges too close");
endmodule
bind sfl_spi_top sfl_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rd(i_rd),
  .i_halt(i_halt), .i_int_mask(i_int_mask), .i_ss_n(i_ss_n), .o_rdata(o_rdata), .o_sck(o_sck),
  .o_sck_oe_n(o_sck_oe_n), .o_mosi(o_mosi), .o_mosi_oe_n(o_mosi_oe_n),
  .o_miso_oe_n(o_miso_oe_n), .o_irq(o_irq));
`default_nettype wire

// File: sim/sfl_partner.sv
// external serial slave in clock mode 0, facing the block as master
// assumes its select is tied active and i_load pulses before each byte
`timescale 1ns/10ps
`default_nettype none
module sfl_partner (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_load,
  input wire logic [7:0] i_tx,
  output logic o_miso,
  output logic [7:0] o_rx
);
  logic [7:0] sh = 8'h00;
  initial o_rx = 8'h00;
  // vacated bits carry a toggling pattern so a stale line never looks right
  always @(posedge i_load or negedge i_sck) begin
    if (i_load)
      sh <= i_tx;
    else
      sh <= {sh[6:0], ~sh[0]};
  end
  always @(posedge i_sck) o_rx <= {o_rx[6:0], i_mosi};
  assign o_miso = sh[7];
endmodule
`default_nettype wire

// File: sim/sfl_spi_top_test.sv
// self-checking bench for the serial block: register port, master and slave bytes
// assumes sfl_partner as external slave; the bench plays external master itself
`timescale 1ns/10ps
`default_nettype none
`include "sfl_defines.vh"
module sfl_spi_top_test;
  localparam logic [7:0] DAT = `SFL_ADDR_DATA;
  localparam logic [7:0] CTL = `SFL_ADDR_CTRL;
  localparam logic [7:0] STA = `SFL_ADDR_STAT;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, mask = 0, halt = 0, ss_n = 1;
  logic tsck = 0, tmosi = 0, load = 0;
  logic [7:0] addr = 0, wdata = 0, ptx = 0, v;
  logic [7:0] rdata, prx;
  logic osck, sck_oe_n, omosi, mosi_oe_n, omiso, miso_oe_n, irq, pmiso;
  int n_fail = 0, cmp_count = 0;
  wire sck_w = sck_oe_n ? tsck : osck;
  wire mosi_w = mosi_oe_n ? tmosi : omosi;
  wire miso_w = miso_oe_n ? pmiso : omiso;
  sfl_spi_top uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_int_mask(mask), .i_halt(halt), .i_sck(sck_w),
    .o_sck(osck), .o_sck_oe_n(sck_oe_n), .i_mosi(mosi_w), .o_mosi(omosi),
    .o_mosi_oe_n(mosi_oe_n), .i_miso(miso_w), .o_miso(omiso), .o_miso_oe_n(miso_oe_n),
    .i_ss_n(ss_n), .o_irq(irq));
  sfl_partner peer (.i_sck(sck_w), .i_mosi(mosi_w), .i_load(load), .i_tx(ptx),
    .o_miso(pmiso), .o_rx(prx));
  initial forever #50 clk = ~clk;
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_r(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_r(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic rc(input string name, input logic [7:0] a, input logic [7:0] exp);
    rd_r(a);
    chk(name, exp, v);
  endtask
  task automatic wait_done();
    v = 8'h00;
    for (int i = 0; i < 300 && v[7] !== 1'b1; i++) rd_r(STA);
  endtask
  task automatic pload(input logic [7:0] tx);
    ptx <= tx;
    wt(1);
    load <= 1'b1;
    wt(1);
    load <= 1'b0;
  endtask
  task automatic t_reset();
    rc("ctrl", CTL, 8'h00);
    rc("status", STA, 8'h00);
    rc("unmapped", 8'h20, 8'h00);
    chk("oe_n", 8'h07, {5'h00, sck_oe_n, mosi_oe_n, miso_oe_n});
  endtask
  task automatic t_master();
    // rate 001: miso needs about three cycles through the synchroniser and pin register
    wr_r(CTL, 8'hD1);
    pload(8'h3C);
    wr_r(DAT, 8'hA5);
    wr_r(DAT, 8'h11);
    #1 chk("irq", 8'h00, {7'h00, irq});
    wait_done();
    chk("status", 8'hC0, v);
    chk("irq", 8'h01, {7'h00, irq});
    wt(1);
    mask <= 1'b1;
    wt(2);
    #1 chk("irq", 8'h00, {7'h00, irq});
    wt(1);
    mask <= 1'b0;
    rc("data", DAT, 8'h3C);
    chk("rx", 8'hA5, prx);
    rc("status", STA, 8'h00);
  endtask
  task automatic t_halt();
    wr_r(CTL, 8'h50);
    pload(8'h81);
    wr_r(DAT, 8'h69);
    wt(6);
    halt <= 1'b1;
    wt(20);
    wr_r(CTL, 8'h00);
    halt <= 1'b0;
    wait_done();
    rc("ctrl", CTL, 8'h50);
    rc("data", DAT, 8'h81);
    chk("rx", 8'h69, prx);
  endtask
  task automatic t_fault();
    wr_r(CTL, 8'hF8);
    wt(2);
    #1 chk("sck", 8'h01, {7'h00, osck});
    wt(1);
    ss_n <= 1'b0;
    wt(8);
    rc("ctrl", CTL, 8'hA8);
    chk("irq", 8'h01, {7'h00, irq});
    wr_r(CTL, 8'hF8);
    rc("ctrl", CTL, 8'hA8);
    wt(1);
    ss_n <= 1'b1;
    wt(4);
    rc("status", STA, 8'h10);
    wr_r(CTL, 8'h00);
    rc("status", STA, 8'h00);
  endtask
  // idle high, phase set: falling edge launches, rising edge captures
  task automatic sl_byte(input logic [7:0] tx, input logic [7:0] exp, input bit see);
    for (int i = 7; i >= 0; i--) begin
      tsck <= 1'b0;
      tmosi <= tx[i];
      wt(5);
      #1 if (see) chk("miso", {7'h00, exp[i]}, {7'h00, miso_w});
      wt(1);
      tsck <= 1'b1;
      wt(2);
    end
  endtask
  task automatic t_slave();
    wt(1);
    tsck <= 1'b1;
    wr_r(CTL, 8'h4C);
    wr_r(DAT, 8'h96);
    ss_n <= 1'b0;
    wt(3);
    #1 chk("miso_oe", 8'h01, {7'h00, miso_oe_n});
    wt(1);
    sl_byte(8'h5A, 8'h96, 1'b1);
    sl_byte(8'hC3, 8'h00, 1'b0);
    ss_n <= 1'b1;
    rc("status", STA, 8'h80);
    rc("data", DAT, 8'h5A);
    wr_r(CTL, 8'h48);
    ss_n <= 1'b0;
    wt(4);
    wr_r(DAT, 8'h00);
    rc("status", STA, 8'h40);
    wt(1);
    ss_n <= 1'b1;
  endtask
  initial begin
    wt(2);
    rst_n <= 1'b1;
    t_reset();
    t_master();
    t_halt();
    t_fault();
    t_slave();
    finish_test();
  end
  // whole run needs well under a thousand cycles; the 20000-cycle limit leaves ample margin
  initial begin
    #2000000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
